// *** shared/cwic_regs.svh ***
`ifndef CWIC_REGS_SVH
`define CWIC_REGS_SVH
// Byte offsets of the software registers.
`define CWIC_OFF_POWER_CTRL_REG    8'h00
`define CWIC_OFF_CMP_CONFIG_REG   8'h04
`define CWIC_OFF_OSC_CMP_CTRL_REG   8'h08
`define CWIC_OFF_IRQ_ENABLE_REG    8'h0c
`define CWIC_OFF_IRQ_FLAG_REG    8'h10
`define CWIC_OFF_STATUS  8'h14
`define CWIC_OFF_WCFG    8'h18
`define CWIC_OFF_VECTOR  8'h1c
// Field positions.
`define CWIC_B_WDOG_RUN_ENABLE     7
`define CWIC_B_COMPARATOR_ENABLE     2
`define CWIC_B_PRESCALER_TO_WDOG    1
`define CWIC_B_CMPRES    7
`define CWIC_B_CMPDRV    6
`define CWIC_B_WDOG_IRQ_FLAG     6
`define CWIC_B_CMP_IRQ_FLAG     7
`define CWIC_B_TOFLAG    4
`define CWIC_B_GIE       0
`define CWIC_B_WCFG_EN   0
`define CWIC_B_WCFG_IRQ  1
`define CWIC_B_WCFG_PS   4
// Vector addresses.
`define CWIC_VEC_SOFT    12'h001
`define CWIC_VEC_HARD    12'h008
// Reset values.
`define CWIC_RST_POWER_CTRL_REG    8'h00
`define CWIC_RST_CMP_CONFIG_REG   8'h00
`define CWIC_RST_WCFG    8'h01
// Watchdog base periods in microseconds.
`define CWIC_WDT_P0_US   3500
`define CWIC_WDT_P1_US   15000
`define CWIC_WDT_P2_US   60000
`define CWIC_WDT_P3_US   250000
// AXI response codes.
`define CWIC_RESP_OKAY   2'h0
`define CWIC_RESP_SLVERR 2'h2
`endif

// *** shared/cwic_pkg.sv ***
package cwic_pkg;
	// Interface state machine of the CPU handshake, one-hot.
	typedef enum logic [2:0]
	{
		CWIC_IDLE  = 3'b001,
		CWIC_SOFT  = 3'b010,
		CWIC_HARD  = 3'b100
	} cwic_vec_t;
endpackage : cwic_pkg

// *** verilog/cwic_ctrl.sv ***
`include "cwic_regs.svh"

module cwic_ctrl #(
	parameter int          CLK_HZ   = 20000000, // System clock rate.
	parameter int unsigned WDT_TICK = 20        // Cycles per microsecond tick of watchdog.
) (
	input  wire logic        clk_sys,        // System clock.
	input  wire logic        rst,            // Synchronous reset, active high.
	input  wire logic [7:0]  s_axi_awaddr,   // Write address.
	input  wire logic        s_axi_awvalid,  // Write address valid.
	output logic             s_axi_awready,  // Write address ready.
	input  wire logic [31:0] s_axi_wdata,    // Write data.
	input  wire logic [3:0]  s_axi_wstrb,    // Write strobes.
	input  wire logic        s_axi_wvalid,   // Write data valid.
	output logic             s_axi_wready,   // Write data ready.
	output logic [1:0]       s_axi_bresp,    // Write response.
	output logic             s_axi_bvalid,   // Write response valid.
	input  wire logic        s_axi_bready,   // Write response ready.
	input  wire logic [7:0]  s_axi_araddr,   // Read address.
	input  wire logic        s_axi_arvalid,  // Read address valid.
	output logic             s_axi_arready,  // Read address ready.
	output logic [31:0]      s_axi_rdata,    // Read data.
	output logic [1:0]       s_axi_rresp,    // Read response.
	output logic             s_axi_rvalid,   // Read data valid.
	input  wire logic        s_axi_rready,   // Read ready.
	input  wire logic        halt_mode,      // Device is in halt mode.
	input  wire logic        cmp_raw,        // Live analog comparator output.
	input  wire logic        tmr0_ovf,       // Timer 0 overflow pulse.
	input  wire logic        tmr1_udf,       // Timer 1 underflow pulse.
	input  wire logic        tmr2_udf,       // Timer 2 underflow pulse.
	input  wire logic [7:0]  portb_change,   // Per-line port B change pulses.
	input  wire logic        ext_pin_edge,   // Selected edge on port B line 0.
	input  wire logic        ext_pin_irq_select, // Line 0 used as external interrupt.
	input  wire logic        pwm_channel_one, // First PWM channel output.
	input  wire logic        sw_irq_instr,   // Software interrupt instruction executed.
	input  wire logic        irq_on_instr,   // Enable-interrupts instruction.
	input  wire logic        irq_off_instr,  // Disable-interrupts instruction.
	input  wire logic        irq_return_instr, // Return-from-interrupt instruction.
	input  wire logic        clear_wdog_instr, // Clear-watchdog instruction.
	output logic             cmp_power_on,   // Comparator analog enable.
	output logic             pad_to_pad_mode, // Pad-to-pad mode active.
	output logic             pad_to_vref_mode, // Pad-to-reference mode active.
	output logic [3:0]       vref_level,     // Reference n/16 of supply, 0 in pad-to-pad mode.
	output logic [15:0]      noninv_sel,     // One-hot non-inverting pad: A0..A7, B0..B7.
	output logic [15:0]      inv_sel,        // One-hot inverting pad, zero selects reference.
	output logic             port_b_line6,   // Pin value for port B line 6.
	output logic             port_b_line6_oe, // Comparator owns port B line 6.
	output logic             vec_fetch,      // Fetch a vector now, one-cycle pulse.
	output logic [11:0]      vec_addr,       // Vector address to fetch.
	output logic             wdog_reset      // Watchdog reset request, one-cycle pulse.
);

	// ****************************************************************
	// Constants
	// ****************************************************************

	// Watchdog base periods in ticks of one microsecond.
	localparam logic [17:0] WDT_P0 = 18'(`CWIC_WDT_P0_US);
	localparam logic [17:0] WDT_P1 = 18'(`CWIC_WDT_P1_US);
	localparam logic [17:0] WDT_P2 = 18'(`CWIC_WDT_P2_US);
	localparam logic [17:0] WDT_P3 = 18'(`CWIC_WDT_P3_US);

	// ****************************************************************
	// State
	// ****************************************************************

	typedef struct packed {
		logic [7:0]  power_ctrl_reg;      // Power control: run enable, comparator enable.
		logic [7:0]  cmp_config_reg;     // Pad select high nibble, reference low.
		logic        cmp_drv;   // Comparator pin drive.
		logic [7:0]  irq_enable_reg;      // Interrupt enables.
		logic [7:0]  irq_flag_reg;      // Raw interrupt flags.
		logic        to_n;      // Active-low timeout flag.
		logic        global_irq_enable;       // Global interrupt enable.
		logic [7:0]  wcfg;      // Watchdog configuration.
		logic        s1;        // Comparator synchroniser stage one.
		logic        s2;        // Comparator synchroniser stage two.
		logic        cmp_copy;  // Registered comparator copy.
		logic [4:0]  tick;      // Microsecond tick divider.
		logic [17:0] wcnt;      // Watchdog base count.
		logic [7:0]  pre;       // Shared prescaler count.
		logic        wrst;      // Watchdog reset pulse.
		logic        aw_ok;     // Write address captured.
		logic        w_ok;      // Write data captured.
		logic [7:0]  awa;       // Captured write address.
		logic [31:0] wd;        // Captured write data.
		logic        bv;        // Write response valid.
		logic [1:0]  br;        // Write response code.
		logic        rv;        // Read data valid.
		logic [31:0] rd;        // Read data.
		logic [1:0]  rr;        // Read response code.
		cwic_pkg::cwic_vec_t vs; // Vector handshake state.
	} cwic_state_t;

	cwic_state_t q;  // Registered state.
	cwic_state_t d;  // Next state.

	// ****************************************************************
	// Combinational decode
	// ****************************************************************

	logic        cmp_on;    // Comparator effectively on.
	logic        cmp_live;  // Synchronised comparator value.
	logic [17:0] wlimit;    // Selected base period.
	logic [7:0]  plimit;    // Prescaler terminal count.
	logic        wdog_run;  // Watchdog is counting.
	logic        base_end;  // Base period reached this cycle.
	logic        wdog_exp;  // Watchdog expiry pulse.
	logic [7:0]  ev;        // Hardware events this cycle.
	logic [7:0]  pend;      // Pending enabled flags.
	logic        do_wr;     // Register write happens.
	logic        do_rd;     // Register read happens.
	logic [31:0] rdv;       // Read mux value.
	logic        rd_ok;     // Read address mapped.

	// Comparator enable gating and mode decode.
	assign cmp_on           = q.power_ctrl_reg[`CWIC_B_COMPARATOR_ENABLE] & ~halt_mode;
	assign pad_to_pad_mode  = (q.cmp_config_reg[3:0] == 4'h0);
	assign pad_to_vref_mode = ~pad_to_pad_mode;
	assign vref_level       = q.cmp_config_reg[3:0];
	assign cmp_live         = q.s2 & cmp_on;

	// Pad routing for both modes; index 0..7 is port A, 8..15 is port B.
	always_comb
	begin
		noninv_sel = 16'h0000;
		inv_sel    = 16'h0000;
		if (!cmp_on)
		begin
			// Nothing is routed while the comparator is off.
			noninv_sel = 16'h0000;
		end
		else if (pad_to_vref_mode)
		begin
			// Code five leaves the input unconnected.
			if (q.cmp_config_reg[7:4] != 4'h5)
				noninv_sel[q.cmp_config_reg[7:4]] = 1'b1;
		end
		else
		begin
			case (q.cmp_config_reg[7:4])
				4'h0: begin noninv_sel[0]  = 1'b1; inv_sel[1]  = 1'b1; end
				4'h1: begin noninv_sel[1]  = 1'b1; inv_sel[0]  = 1'b1; end
				4'h2: begin noninv_sel[2]  = 1'b1; inv_sel[3]  = 1'b1; end
				4'h3: begin noninv_sel[3]  = 1'b1; inv_sel[2]  = 1'b1; end
				4'h4: begin noninv_sel[0]  = 1'b1; inv_sel[11] = 1'b1; end
				4'h5: begin noninv_sel[1]  = 1'b1; inv_sel[10] = 1'b1; end
				4'h6: begin noninv_sel[2]  = 1'b1; inv_sel[13] = 1'b1; end
				4'h7: begin noninv_sel[3]  = 1'b1; inv_sel[12] = 1'b1; end
				4'h8: begin noninv_sel[10] = 1'b1; inv_sel[1]  = 1'b1; end
				4'h9: begin noninv_sel[11] = 1'b1; inv_sel[0]  = 1'b1; end
				4'ha: begin noninv_sel[12] = 1'b1; inv_sel[3]  = 1'b1; end
				4'hb: begin noninv_sel[13] = 1'b1; inv_sel[2]  = 1'b1; end
				4'hc: begin noninv_sel[10] = 1'b1; inv_sel[11] = 1'b1; end
				4'hd: begin noninv_sel[11] = 1'b1; inv_sel[10] = 1'b1; end
				4'he: begin noninv_sel[12] = 1'b1; inv_sel[13] = 1'b1; end
				default: begin noninv_sel[13] = 1'b1; inv_sel[12] = 1'b1; end
			endcase
		end
	end

	// Watchdog period and prescaler selection.
	always_comb
	begin
		case (q.wcfg[3:2])
			2'h0:    wlimit = WDT_P0;
			2'h1:    wlimit = WDT_P1;
			2'h2:    wlimit = WDT_P2;
			default: wlimit = WDT_P3;
		endcase
		// With the prescaler assigned, reset mode divides 1..128, interrupt mode 2..256; otherwise it divides by 1.
		if (!q.power_ctrl_reg[`CWIC_B_PRESCALER_TO_WDOG])
			plimit = 8'h00;
		else if (q.wcfg[`CWIC_B_WCFG_IRQ])
			plimit = 8'((9'h002 << q.wcfg[6:4]) - 9'h001);
		else
			plimit = 8'((9'h001 << q.wcfg[6:4]) - 9'h001);
	end

	// The watchdog ignores halt and standby on purpose.
	assign wdog_run = q.wcfg[`CWIC_B_WCFG_EN] & q.power_ctrl_reg[`CWIC_B_WDOG_RUN_ENABLE];
	assign base_end = wdog_run && (q.tick == 5'(WDT_TICK - 1)) && (q.wcnt == wlimit - 18'h1);
	assign wdog_exp = base_end && (q.pre == plimit) && !clear_wdog_instr;

	// Hardware event vector: 0 t0, 1 t1, 2 t2, 3 pb change, 4 ext, 6 wdog, 7 cmp.
	always_comb
	begin
		ev    = 8'h00;
		ev[0] = tmr0_ovf;
		ev[1] = tmr1_udf;
		ev[2] = tmr2_udf;
		ev[3] = |{portb_change[7:1], portb_change[0] & ~ext_pin_irq_select};
		ev[4] = ext_pin_edge & ext_pin_irq_select;
		ev[`CWIC_B_WDOG_IRQ_FLAG] = wdog_exp & q.wcfg[`CWIC_B_WCFG_IRQ];
		ev[`CWIC_B_CMP_IRQ_FLAG] = cmp_live ^ q.cmp_copy;
	end

	assign pend  = q.irq_flag_reg & q.irq_enable_reg;
	assign do_wr = q.aw_ok && q.w_ok && !q.bv;
	assign do_rd = s_axi_arvalid && !q.rv;

	// Read multiplexer.
	always_comb
	begin
		rdv   = 32'h0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`CWIC_OFF_POWER_CTRL_REG:   rdv[7:0] = q.power_ctrl_reg;
			`CWIC_OFF_CMP_CONFIG_REG:  rdv[7:0] = q.cmp_config_reg;
			`CWIC_OFF_OSC_CMP_CTRL_REG:  rdv[7:0] = {cmp_live, q.cmp_drv, 6'h0};
			`CWIC_OFF_IRQ_ENABLE_REG:   rdv[7:0] = q.irq_enable_reg;
			`CWIC_OFF_IRQ_FLAG_REG:   rdv[7:0] = pend;
			`CWIC_OFF_STATUS: rdv[7:0] = 8'(q.to_n) << `CWIC_B_TOFLAG;
			`CWIC_OFF_WCFG:   rdv[7:0] = q.wcfg;
			`CWIC_OFF_VECTOR: rdv[0]   = q.global_irq_enable;
			default:          rd_ok    = 1'b0;
		endcase
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	always_comb
	begin
		d          = q;
		d.wrst     = 1'b0;
		d.s1       = cmp_raw;
		d.s2       = q.s1;
		// Bus channel handshakes.
		if (s_axi_awvalid && !q.aw_ok)
		begin
			d.aw_ok = 1'b1;
			d.awa   = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_ok)
		begin
			d.w_ok = 1'b1;
			d.wd   = s_axi_wdata;
		end
		if (q.bv && s_axi_bready)
			d.bv = 1'b0;
		if (q.rv && s_axi_rready)
			d.rv = 1'b0;
		// Watchdog tick, base count and prescaler.
		if (!wdog_run || clear_wdog_instr)
		begin
			d.tick = 5'h0;
			d.wcnt = 18'h0;
			d.pre  = 8'h0;
		end
		else if (q.tick == 5'(WDT_TICK - 1))
		begin
			d.tick = 5'h0;
			d.wcnt = base_end ? 18'h0 : q.wcnt + 18'h1;
			if (base_end)
				d.pre = (q.pre == plimit) ? 8'h0 : q.pre + 8'h1;
		end
		else
			d.tick = q.tick + 5'h1;
		if (clear_wdog_instr && q.power_ctrl_reg[`CWIC_B_PRESCALER_TO_WDOG])
			d.to_n = 1'b1;
		if (wdog_exp)
		begin
			d.to_n = 1'b0;
			d.wrst = ~q.wcfg[`CWIC_B_WCFG_IRQ];
		end
		// Register writes; flags only clear where a zero is written.
		if (do_wr)
		begin
			d.aw_ok = 1'b0;
			d.w_ok  = 1'b0;
			d.bv    = 1'b1;
			d.br    = `CWIC_RESP_OKAY;
			if (!s_axi_wstrb[0])
				d.br = `CWIC_RESP_OKAY;
			else
				case (q.awa)
					`CWIC_OFF_POWER_CTRL_REG:  d.power_ctrl_reg    = q.wd[7:0];
					`CWIC_OFF_CMP_CONFIG_REG: d.cmp_config_reg   = q.wd[7:0];
					`CWIC_OFF_OSC_CMP_CTRL_REG: d.cmp_drv = q.wd[`CWIC_B_CMPDRV];
					`CWIC_OFF_IRQ_ENABLE_REG:  d.irq_enable_reg    = q.wd[7:0];
					`CWIC_OFF_IRQ_FLAG_REG:  d.irq_flag_reg    = q.irq_flag_reg & q.wd[7:0];
					`CWIC_OFF_WCFG:  d.wcfg    = q.wd[7:0];
					`CWIC_OFF_STATUS: d.br     = `CWIC_RESP_OKAY;
					`CWIC_OFF_VECTOR: d.br     = `CWIC_RESP_OKAY;
					default:         d.br      = `CWIC_RESP_SLVERR;
				endcase
		end
		// Events win over a clear in the same cycle.
		d.irq_flag_reg = d.irq_flag_reg | ev;
		// Reading the control register refreshes the comparator copy.
		if (do_rd)
		begin
			d.rv = 1'b1;
			d.rd = rdv;
			d.rr = rd_ok ? `CWIC_RESP_OKAY : `CWIC_RESP_SLVERR;
			if (s_axi_araddr == `CWIC_OFF_OSC_CMP_CTRL_REG)
				d.cmp_copy = cmp_live;
		end
		// Global enable and vector selection; software interrupt first.
		d.vs = cwic_pkg::CWIC_IDLE;
		case (1'b1)
			sw_irq_instr:
			begin
				d.global_irq_enable = 1'b0;
				d.vs  = cwic_pkg::CWIC_SOFT;
			end
			q.global_irq_enable && (|pend) && q.vs == cwic_pkg::CWIC_IDLE:
			begin
				d.global_irq_enable = 1'b0;
				d.vs  = cwic_pkg::CWIC_HARD;
			end
			irq_on_instr:     d.global_irq_enable = 1'b1;
			irq_return_instr: d.global_irq_enable = 1'b1;
			irq_off_instr:    d.global_irq_enable = 1'b0;
			default:          d.global_irq_enable = q.global_irq_enable;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			q       <= '0;
			q.power_ctrl_reg  <= `CWIC_RST_POWER_CTRL_REG;
			q.cmp_config_reg <= `CWIC_RST_CMP_CONFIG_REG;
			q.wcfg  <= `CWIC_RST_WCFG;
			q.to_n  <= 1'b1;
			q.vs    <= cwic_pkg::CWIC_IDLE;
		end
		else
			q <= d;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	assign s_axi_awready   = ~q.aw_ok;
	assign s_axi_wready    = ~q.w_ok;
	assign s_axi_bvalid    = q.bv;
	assign s_axi_bresp     = q.br;
	assign s_axi_arready   = ~q.rv;
	assign s_axi_rvalid    = q.rv;
	assign s_axi_rdata     = q.rd;
	assign s_axi_rresp     = q.rr;
	assign cmp_power_on    = cmp_on;
	// Pin drive replaces the PWM channel with the live result.
	assign port_b_line6    = q.cmp_drv ? cmp_live : pwm_channel_one;
	assign port_b_line6_oe = q.cmp_drv;
	assign vec_fetch       = (q.vs != cwic_pkg::CWIC_IDLE);
	assign vec_addr        = (q.vs == cwic_pkg::CWIC_SOFT) ? `CWIC_VEC_SOFT : `CWIC_VEC_HARD;
	assign wdog_reset      = q.wrst;

	// ****************************************************************
	// Assertions
	// ****************************************************************

	a_cmp_halt_off: assert property (@(posedge clk_sys) disable iff (rst) halt_mode |-> !cmp_power_on)
		else $error("comparator on in halt");
	a_mode_decode: assert property (@(posedge clk_sys) disable iff (rst)
		pad_to_pad_mode == (vref_level == 4'h0))
		else $error("mode decode wrong");
	a_cmp_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
		(cmp_live != q.cmp_copy) |=> q.irq_flag_reg[`CWIC_B_CMP_IRQ_FLAG])
		else $error("comparator flag not set");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		q.irq_flag_reg[0] && !do_wr |=> q.irq_flag_reg[0])
		else $error("flag lost without write");
	a_soft_vector: assert property (@(posedge clk_sys) disable iff (rst)
		sw_irq_instr |=> vec_fetch && vec_addr == `CWIC_VEC_SOFT && !q.global_irq_enable)
		else $error("soft vector wrong");
	a_hard_vector: assert property (@(posedge clk_sys) disable iff (rst)
		q.global_irq_enable && |pend && !sw_irq_instr && q.vs == cwic_pkg::CWIC_IDLE
		|=> vec_fetch && vec_addr == `CWIC_VEC_HARD && !q.global_irq_enable)
		else $error("hard vector wrong");
	a_gie_on: assert property (@(posedge clk_sys) disable iff (rst)
		irq_on_instr && !sw_irq_instr && !(q.global_irq_enable && |pend) |=> q.global_irq_enable)
		else $error("enable instruction ignored");
	a_timeout_flag: assert property (@(posedge clk_sys) disable iff (rst)
		wdog_exp |=> !q.to_n)
		else $error("timeout flag not cleared");
	a_wdt_flag: assert property (@(posedge clk_sys) disable iff (rst)
		wdog_exp && q.wcfg[`CWIC_B_WCFG_IRQ] |=> q.irq_flag_reg[`CWIC_B_WDOG_IRQ_FLAG])
		else $error("watchdog flag not set");
	a_pin_drive: assert property (@(posedge clk_sys) disable iff (rst)
		q.cmp_drv |-> port_b_line6 == cmp_live)
		else $error("pin not showing result");

	c_hard_irq: cover property (@(posedge clk_sys) disable iff (rst) q.vs == cwic_pkg::CWIC_HARD);
	c_soft_irq: cover property (@(posedge clk_sys) disable iff (rst) q.vs == cwic_pkg::CWIC_SOFT);
	c_wdt_exp:  cover property (@(posedge clk_sys) disable iff (rst) wdog_exp);
	c_cmp_chg:  cover property (@(posedge clk_sys) disable iff (rst) ev[7]);

endmodule : cwic_ctrl

// *** test/cwic_cpu_model.sv ***
module cwic_cpu_model (
	input  wire logic        clk_sys,   // System clock.
	input  wire logic        rst,       // Synchronous reset, active high.
	input  wire logic [4:0]  cmd,       // Request, one-hot: soft, on, off, return, clear.
	input  wire logic        vec_fetch, // Fetch strobe from the controller.
	input  wire logic [11:0] vec_addr,  // Address of that fetch.
	output logic [4:0]       instr,     // Executed instruction pulses.
	output logic [11:0]      last_vec,  // Last vector fetched.
	output logic [7:0]       fetches    // Count of vectors taken.
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Sequencer
	// ****
	// A request executes one cycle later, as after decode in the core.
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			instr    <= 5'h00;
			last_vec <= 12'h000;
			fetches  <= 8'h00;
		end
		else
		begin
			instr <= cmd;
			if (vec_fetch)
			begin
				last_vec <= vec_addr;
				fetches  <= fetches + 8'h01;
			end
		end
	end
endmodule : cwic_cpu_model

// *** test/tb.sv ***
`include "cwic_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Signals
	// ****
	logic        clk_sys = 1'h0, rst = 1'h1, halt_mode = 1'h0, cmp_raw = 1'h0;
	logic        ext_pin_irq_select = 1'h0, pwm_channel_one = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, portb_change = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, rdat;
	logic [3:0]  s_axi_wstrb = 4'hf, ev = 4'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [4:0]  cmd = 5'h00;
	logic [1:0]  resp;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic   cmp_power_on, pad_to_pad_mode, pad_to_vref_mode, port_b_line6, port_b_line6_oe;
	wire logic   vec_fetch, wdog_reset;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [3:0]  vref_level;
	wire logic [15:0] noninv_sel, inv_sel;
	wire logic [11:0] vec_addr, last_vec;
	wire logic [7:0]  fetches;
	wire logic [4:0]  instr;
	wire logic   tmr0_ovf = ev[0], tmr1_udf = ev[1], tmr2_udf = ev[2], ext_pin_edge = ev[3];
	wire logic   sw_irq_instr = instr[0], irq_on_instr = instr[1], irq_off_instr = instr[2];
	wire logic   irq_return_instr = instr[3], clear_wdog_instr = instr[4];
	int          num_errors = 0, comparisons = 0, i;
	// Pad-pair codes per pad select value, one nibble each: port A line n is n, port B line n is 8+n.
	localparam logic [63:0] P2P_NI  = 64'hdcba_dcba_3210_3210;
	localparam logic [63:0] P2P_INV = 64'hcdab_2301_cdab_2301;
	// A short watchdog tick keeps the base periods at their figure in clock cycles.
	cwic_ctrl #(.WDT_TICK(1)) u_cwic_ctrl (.*);
	cwic_cpu_model u_cwic_cpu_model (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .vec_fetch(vec_fetch),
		.vec_addr(vec_addr), .instr(instr), .last_vec(last_vec), .fetches(fetches));
	always #25 clk_sys = ~clk_sys;
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	// A bus wait that ran out means the slave hung; stop at once.
	task automatic tmo(input int n);
		if (n >= 64)
		begin
			num_errors++;
			$display("Error %0t: bus timeout", $time);
			conclude();
		end
	endtask : tmo
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid && n < 64);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		tmo(n);
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid && n < 64);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		tmo(n);
		@(posedge clk_sys);
	endtask : rd
	// The idle gap after each instruction keeps an enable never right before a return.
	task automatic ins(input int k);
		cmd <= 5'h01 << k;
		@(posedge clk_sys);
		cmd <= 5'h00;
		repeat (5) @(posedge clk_sys);
	endtask : ins
	task automatic pz(input logic [3:0] e, input logic [7:0] p);
		ev           <= e;
		portb_change <= p;
		@(posedge clk_sys);
		ev           <= 4'h0;
		portb_change <= 8'h00;
		repeat (3) @(posedge clk_sys);
	endtask : pz
	// Waits for a timeout pulse; in interrupt mode none may come.
	task automatic wdt(input int p, input logic rm);
		int n;
		n = 0;
		while (!wdog_reset && n < p + 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk({wdog_reset, n > p - 20 || !rm}, {rm, 1'h1});
	endtask : wdt
	// ****
	// Scenarios
	// ****
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		rd(`CWIC_OFF_WCFG);
		chk(rdat, 32'h1);
		rd(`CWIC_OFF_STATUS);
		chk(rdat[4], 1'h1);
		rd(8'h20);
		chk({resp, cmp_power_on}, {`CWIC_RESP_SLVERR, 1'h0});
		$display("Test reset finished");
		wr(`CWIC_OFF_POWER_CTRL_REG, 32'h04);
		chk({resp, cmp_power_on}, {`CWIC_RESP_OKAY, 1'h1});
		for (i = 0; i < 16; i++)
		begin
			wr(`CWIC_OFF_CMP_CONFIG_REG, {24'h0, i[3:0], 4'h0});
			chk({pad_to_pad_mode, pad_to_vref_mode, inv_sel, noninv_sel},
				{2'h2, 16'h1 << P2P_INV[4*i+:4], 16'h1 << P2P_NI[4*i+:4]});
			wr(`CWIC_OFF_CMP_CONFIG_REG, {24'h0, i[3:0], 4'((i % 15) + 1)});
			chk({pad_to_vref_mode, vref_level, inv_sel, noninv_sel},
				{1'h1, 4'((i % 15) + 1), 16'h0, (i == 5) ? 16'h0 : 16'h1 << i});
		end
		wr(`CWIC_OFF_IRQ_ENABLE_REG, 32'hff);
		rd(`CWIC_OFF_OSC_CMP_CTRL_REG);
		wr(`CWIC_OFF_IRQ_FLAG_REG, 32'h0);
		cmp_raw <= 1'h1;
		repeat (6) @(posedge clk_sys);
		rd(`CWIC_OFF_IRQ_FLAG_REG);
		chk(rdat, 32'h80);
		rd(`CWIC_OFF_OSC_CMP_CTRL_REG);
		chk(rdat[7], 1'h1);
		wr(`CWIC_OFF_IRQ_FLAG_REG, 32'h0);
		rd(`CWIC_OFF_IRQ_FLAG_REG);
		chk(rdat, 32'h0);
		wr(`CWIC_OFF_OSC_CMP_CTRL_REG, 32'h40);
		pwm_channel_one <= 1'h1;
		cmp_raw         <= 1'h0;
		repeat (6) @(posedge clk_sys);
		chk({port_b_line6_oe, port_b_line6}, 2'h2);
		wr(`CWIC_OFF_OSC_CMP_CTRL_REG, 32'h0);
		chk({port_b_line6_oe, port_b_line6}, 2'h1);
		rd(`CWIC_OFF_OSC_CMP_CTRL_REG);
		wr(`CWIC_OFF_IRQ_FLAG_REG, 32'h0);
		$display("Test comparator finished");
		// The pin edge only counts as an event while line 0 is the external input.
		ext_pin_irq_select <= 1'h1;
		for (i = 0; i < 4; i++)
		begin
			pz(4'h1 << i, 8'h00);
			rd(`CWIC_OFF_IRQ_FLAG_REG);
			chk(rdat, 32'h1 << ((i == 3) ? 4 : i));
			wr(`CWIC_OFF_IRQ_FLAG_REG, 32'h0);
		end
		pz(4'h0, 8'h01);
		rd(`CWIC_OFF_IRQ_FLAG_REG);
		chk(rdat, 32'h0);
		pz(4'h0, 8'h02);
		rd(`CWIC_OFF_IRQ_FLAG_REG);
		chk(rdat, 32'h08);
		ext_pin_irq_select <= 1'h0;
		wr(`CWIC_OFF_IRQ_ENABLE_REG, 32'h0);
		wr(`CWIC_OFF_IRQ_FLAG_REG, 32'h0);
		pz(4'h1, 8'h00);
		rd(`CWIC_OFF_IRQ_FLAG_REG);
		chk(rdat, 32'h0);
		wr(`CWIC_OFF_IRQ_ENABLE_REG, 32'h01);
		rd(`CWIC_OFF_IRQ_FLAG_REG);
		chk(rdat, 32'h1);
		ins(1);
		rd(`CWIC_OFF_VECTOR);
		chk({last_vec, rdat[0]}, {`CWIC_VEC_HARD, 1'h0});
		wr(`CWIC_OFF_IRQ_FLAG_REG, 32'h0);
		ins(3);
		rd(`CWIC_OFF_VECTOR);
		chk(rdat[0], 1'h1);
		ins(0);
		rd(`CWIC_OFF_VECTOR);
		chk({fetches, last_vec, rdat[0]}, {8'h02, `CWIC_VEC_SOFT, 1'h0});
		ins(1);
		rd(`CWIC_OFF_VECTOR);
		chk(rdat[0], 1'h1);
		ins(2);
		rd(`CWIC_OFF_VECTOR);
		chk(rdat[0], 1'h0);
		$display("Test interrupts finished");
		halt_mode <= 1'h1;
		wr(`CWIC_OFF_POWER_CTRL_REG, 32'h84);
		chk({cmp_power_on, noninv_sel}, 17'h0);
		wdt(3500, 1'h1);
		halt_mode <= 1'h0;
		rd(`CWIC_OFF_STATUS);
		chk(rdat[4], 1'h0);
		wr(`CWIC_OFF_POWER_CTRL_REG, 32'h02);
		wdt(4000, 1'h0);
		ins(4);
		rd(`CWIC_OFF_STATUS);
		chk(rdat[4], 1'h1);
		wr(`CWIC_OFF_WCFG, 32'h11);
		wr(`CWIC_OFF_POWER_CTRL_REG, 32'h82);
		wdt(7000, 1'h1);
		ins(4);
		wr(`CWIC_OFF_WCFG, 32'h03);
		wr(`CWIC_OFF_IRQ_ENABLE_REG, 32'h40);
		wr(`CWIC_OFF_IRQ_FLAG_REG, 32'h0);
		wr(`CWIC_OFF_POWER_CTRL_REG, 32'h80);
		wdt(3500, 1'h0);
		rd(`CWIC_OFF_IRQ_FLAG_REG);
		chk(rdat, 32'h40);
		wr(`CWIC_OFF_POWER_CTRL_REG, 32'h02);
		ins(4);
		wr(`CWIC_OFF_WCFG, 32'h05);
		wr(`CWIC_OFF_POWER_CTRL_REG, 32'h80);
		wdt(15000, 1'h1);
		$display("Test watchdog finished");
		conclude();
	end
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		$display("Error %0t: run timeout", $time);
		conclude();
	end
endmodule : tb
